// File: logic/typec_source_attach_logic.sv
// Downstream-facing Type-C port attach, orientation and VCONN logic.
//
// What this block does
// - Classify each CC pin open, Rd or Ra.
// - Rd on one pin: converter, gate on unless in client mode.
// - Rd plus Ra: VCONN on the Ra pin.
// - Rd/Rd or Ra/Ra: unsupported, all off.
// - Flags only pull low or float.
// - External current limit selected whenever port_ctrl_hi is high.
// - Orientation flag low for Rd on CC2.
// - No sink: orientation flag stays released.
// - Over-temperature turns outputs off, auto restart.
// - VCONN fault flag deglitched, VCONN kept on.
// - Converter waits for the debounce time.
`include "typec_cfg.svh"

module typec_source_attach_logic
   import typec_pkg::*;
#(
   parameter int CC_DEBOUNCE_CYC    = `CC_DEBOUNCE_CYC,
   parameter int VCONN_DEGLITCH_CYC = `VCONN_DEGLITCH_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // CC comparator results
   input  wire logic [1:0]  cc1_term,
   input  wire logic [1:0]  cc2_term,
   // Control and protection inputs
   input  wire logic        port_ctrl_hi,
   input  wire logic        port_ctrl_lo,
   input  wire logic        overtemp_limit,
   input  wire logic        vconn_current_limit,
   // Power path controls
   output logic             converter_en,
   output logic             load_switch_gate,
   output logic             vconn_cc1_en,
   output logic             vconn_cc2_en,
   output logic             adv_current_3a,
   output logic             ilimit_external,
   output logic             client_mode,
   // Open-drain flags
   output logic             orientation_flag_n_o,
   output logic             orientation_flag_n_oe,
   output logic             load_detect_n_o,
   output logic             load_detect_n_oe,
   output logic             fault_n_o,
   output logic             fault_n_oe,
   // Interrupt
   output logic             irq
);

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Code 2'h3 is not a real termination and is read as open.
   function automatic logic is_term(cc_term_t t, cc_term_t code);
      return t == code;
   endfunction

   function automatic port_state_t next_state(cc_term_t a, cc_term_t b,
                                              logic hot, logic en);
      port_state_t s;
      s = ST_UNATTACHED;
      if (hot) begin
         s = ST_HOT;
      end else if (!en) begin
         s = ST_UNATTACHED;
      end else if ((is_term(a, `CC_RD) && is_term(b, `CC_RD)) ||
                   (is_term(a, `CC_RA) && is_term(b, `CC_RA))) begin
         s = ST_ACCESSORY;
      end else if (is_term(a, `CC_RD) || is_term(b, `CC_RD)) begin
         s = ST_SINK;
      end
      return s;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] cc_raw [2];
   logic [1:0] cc_sync [2];
   logic [1:0] cc_deb [2];
   logic [3:0] misc_sync;
   logic       vfault_deb;

   assign cc_raw[0] = cc1_term;
   assign cc_raw[1] = cc2_term;

   // Classify both pins with a debounce filter.
   // per-pin classification
   for (genvar i = 0; i < 2; i++) begin : g_cc
      sync2 #(
         .W (2)
      ) u_sync (
         .clk  (clk),
         .srst (srst),
         .din  (cc_raw[i]),
         .dout (cc_sync[i])
      );

      level_filter #(
         .W      (2),
         .CYCLES (CC_DEBOUNCE_CYC)
      ) u_deb (
         .clk  (clk),
         .srst (srst),
         .din  (cc_sync[i]),
         .dout (cc_deb[i])
      );
   end

   sync2 #(
      .W (4)
   ) u_sync_misc (
      .clk  (clk),
      .srst (srst),
      .din  ({vconn_current_limit, overtemp_limit, port_ctrl_lo, port_ctrl_hi}),
      .dout (misc_sync)
   );

   level_filter #(
      .W      (1),
      .CYCLES (VCONN_DEGLITCH_CYC)
   ) u_vfault (
      .clk  (clk),
      .srst (srst),
      .din  (misc_sync[3]),
      .dout (vfault_deb)
   );

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   port_mode_t mode;

   assign mode.client    = !misc_sync[0];
   assign mode.adv_3a    = misc_sync[0] && misc_sync[1];
   // external limit in SDP and CDP
   assign mode.ext_limit = misc_sync[0];

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic                port_en_r;
   logic [`INT_W-1:0]   int_stat_r;
   logic [`INT_W-1:0]   int_mask_r;
   logic [`INT_W-1:0]   int_event;
   logic [`INT_W-1:0]   int_clr;
   logic                vfault_prev_r;
   logic                hot_prev_r;

   // ------------------------------------------------------------
   // Attach state machine
   // ------------------------------------------------------------
   port_state_t state_r;
   port_state_t state_nxt;
   logic        hot;

   // thermal comparator holds its own hysteresis
   assign hot = misc_sync[2];

   always_comb begin
      state_nxt = next_state(cc_deb[0], cc_deb[1], hot, port_en_r);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= ST_UNATTACHED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // Output drive decode
   // ------------------------------------------------------------
   port_drive_t drive_nxt;
   port_drive_t drive_r;

   always_comb begin
      drive_nxt = '0;
      unique case (state_nxt)
         ST_SINK: begin
            // converter and gate on, client mode keeps bus off
            drive_nxt.converter = !mode.client;
            drive_nxt.gate      = !mode.client;
            drive_nxt.load_det  = 1'b1;
            // VCONN to the pin that shows Ra
            drive_nxt.vconn_cc1 = is_term(cc_deb[0], `CC_RA);
            drive_nxt.vconn_cc2 = is_term(cc_deb[1], `CC_RA);
            // reversed plug pulls the flag low
            drive_nxt.orient    = is_term(cc_deb[1], `CC_RD);
         end
         ST_ACCESSORY: begin
            drive_nxt = '0;
         end
         ST_HOT: begin
            // power path, VCONN, orientation and load flags off while over temperature
            drive_nxt = '0;
         end
         ST_UNATTACHED: begin
            drive_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         drive_r <= '0;
      end else begin
         drive_r <= drive_nxt;
      end
   end

   assign converter_en     = drive_r.converter;
   assign load_switch_gate = drive_r.gate;
   assign vconn_cc1_en     = drive_r.vconn_cc1;
   assign vconn_cc2_en     = drive_r.vconn_cc2;

   // ------------------------------------------------------------
   // Mode outputs
   // ------------------------------------------------------------
   port_mode_t mode_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_r <= '{client: 1'b1, adv_3a: 1'b0, ext_limit: 1'b0};
      end else begin
         mode_r <= mode;
      end
   end

   assign client_mode     = mode_r.client;
   assign adv_current_3a  = mode_r.adv_3a;
   assign ilimit_external = mode_r.ext_limit;

   // ------------------------------------------------------------
   // Open-drain flags
   // ------------------------------------------------------------
   // The pin levels are held low in a register so the enables alone
   // decide whether a flag is pulled down or left floating.
   logic od_low_r;
   logic fault_oe_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         od_low_r   <= 1'b0;
         fault_oe_r <= 1'b0;
      end else begin
         od_low_r   <= 1'b0;
         // fault shown, VCONN path left alone
         fault_oe_r <= vfault_deb;
      end
   end

   assign orientation_flag_n_o  = od_low_r;
   assign load_detect_n_o       = od_low_r;
   assign fault_n_o             = od_low_r;
   assign orientation_flag_n_oe = drive_r.orient;
   assign load_detect_n_oe      = drive_r.load_det;
   assign fault_n_oe            = fault_oe_r;

   // ------------------------------------------------------------
   // Events
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         vfault_prev_r <= 1'b0;
         hot_prev_r    <= 1'b0;
      end else begin
         vfault_prev_r <= vfault_deb;
         hot_prev_r    <= hot;
      end
   end

   always_comb begin
      int_event = '0;
      int_event[`INT_ATTACH] = (state_nxt == ST_SINK) && (state_r != ST_SINK);
      int_event[`INT_DETACH] = (state_r == ST_SINK) && (state_nxt != ST_SINK);
      int_event[`INT_UNSUPP] = (state_nxt == ST_ACCESSORY) &&
                               (state_r != ST_ACCESSORY);
      int_event[`INT_VFAULT] = vfault_deb && !vfault_prev_r;
      int_event[`INT_HOT]    = hot && !hot_prev_r;
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Software can park the port; the state machine then reports
   // unattached (hot while over temperature) and all power paths stay off.
   always_ff @(posedge clk) begin
      if (srst) begin
         port_en_r <= `CTRL_RESET;
      end else if (reg_wr && reg_addr == `REG_CTRL) begin
         port_en_r <= reg_wdata[0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         int_mask_r <= `INT_MASK_RESET;
      end else if (reg_wr && reg_addr == `REG_INT_MASK) begin
         int_mask_r <= reg_wdata[`INT_W-1:0];
      end
   end

   assign int_clr = (reg_wr && reg_addr == `REG_INT_STAT) ?
                    reg_wdata[`INT_W-1:0] : '0;

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge clk) begin
      if (srst) begin
         int_stat_r <= '0;
      end else begin
         int_stat_r <= (int_stat_r & ~int_clr) | int_event;
      end
   end

   // ------------------------------------------------------------
   // Interrupt output
   // ------------------------------------------------------------
   logic irq_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((int_stat_r & ~int_clr) | int_event) & int_mask_r);
      end
   end

   assign irq = irq_r;

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   logic [31:0] rdata_r;
   logic [31:0] status_word;

   assign status_word = {22'h0,
                         mode_r.adv_3a,
                         mode_r.client,
                         vfault_deb,
                         hot,
                         2'(state_r),
                         cc_deb[1],
                         cc_deb[0]};

   // Unmapped addresses and idle cycles read as zero.
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `REG_CTRL:     rdata_r <= {31'h0, port_en_r};
            `REG_STATUS:   rdata_r <= status_word;
            `REG_INT_STAT: rdata_r <= {27'h0, int_stat_r};
            `REG_INT_MASK: rdata_r <= {27'h0, int_mask_r};
            default:       rdata_r <= 32'h0;
         endcase
      end else begin
         rdata_r <= 32'h0;
      end
   end

   assign reg_rdata = rdata_r;

endmodule

// File: shared/typec_cfg.svh
// Offsets, field positions, reset values and timing counts of the attach logic.
`ifndef TYPEC_CFG_SVH
`define TYPEC_CFG_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define CLK_FREQ_KHZ     250000
`define VCONN_DEGLITCH_MS 8
`define CC_DEBOUNCE_MS    100
`define VCONN_DEGLITCH_CYC (`VCONN_DEGLITCH_MS * `CLK_FREQ_KHZ)
`define CC_DEBOUNCE_CYC    (`CC_DEBOUNCE_MS * `CLK_FREQ_KHZ)

// ------------------------------------------------------------
// CC termination codes from the comparators
// ------------------------------------------------------------
`define CC_OPEN 2'h0
`define CC_RD   2'h1
`define CC_RA   2'h2

// ------------------------------------------------------------
// Register map, byte addresses
// ------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_INT_STAT  8'h08
`define REG_INT_MASK  8'h0C
`define CTRL_RESET    1'h1
`define INT_MASK_RESET 5'h00
`define INT_ATTACH    0
`define INT_DETACH    1
`define INT_UNSUPP    2
`define INT_VFAULT    3
`define INT_HOT       4
`define INT_W         5
`endif

// File: shared/typec_pkg.sv
// Types shared by the Type-C source attach logic.
package typec_pkg;
   typedef logic [1:0] cc_term_t;

   typedef enum logic [1:0] {
      ST_UNATTACHED,
      ST_SINK,
      ST_ACCESSORY,
      ST_HOT
   } port_state_t;

   typedef struct packed {
      logic converter;
      logic gate;
      logic vconn_cc1;
      logic vconn_cc2;
      logic orient;
      logic load_det;
   } port_drive_t;

   typedef struct packed {
      logic client;
      logic adv_3a;
      logic ext_limit;
   } port_mode_t;
endpackage

// File: logic/sync2.sv
// Two-flop synchroniser for a vector of independent levels.
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule

// File: logic/level_filter.sv
// Holds a value until a new one has stood unchanged for CYCLES clocks.
module level_filter #(
   parameter int W      = 1,
   parameter int CYCLES = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] prev_r;
   logic [31:0]  cnt_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         prev_r <= '0;
         cnt_r  <= 32'h0;
         dout   <= '0;
      end else begin
         prev_r <= din;
         // A change of the candidate value restarts the wait.
         if (din == dout || din != prev_r) begin
            cnt_r <= 32'h0;
         end else if (cnt_r >= 32'(CYCLES - 1)) begin
            cnt_r <= 32'h0;
            dout  <= din;
         end else begin
            cnt_r <= cnt_r + 32'h1;
         end
      end
   end
endmodule

// File: verification/typec_far_end.sv
// Far-end model: the sink, powered cable or accessory seen on the two CC pins.
module typec_far_end
   import typec_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Terminations at the two plug ends and plug orientation
   input  wire logic [1:0] near_term,
   input  wire logic [1:0] far_term,
   input  wire logic       flipped,
   // Comparator codes seen by the port
   output cc_term_t        cc1_term,
   output cc_term_t        cc2_term
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Plug orientation
   // ------------------------------------------------------------
   // orientation swap
   // A flipped plug swaps which receptacle pin sees which end, as a real cable does.
   always_ff @(posedge clk) begin
      cc1_term <= flipped ? far_term : near_term;
      cc2_term <= flipped ? near_term : far_term;
   end
endmodule

// File: verification/typec_attach_chk.sv
// Concurrent checks on the ports of the Type-C source attach logic.
module typec_attach_chk #(
   parameter int CC_DEBOUNCE_CYC    = 8,
   parameter int VCONN_DEGLITCH_CYC = 8
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Inputs
   input wire logic [1:0] cc1_term,
   input wire logic [1:0] cc2_term,
   input wire logic       port_ctrl_hi,
   input wire logic       port_ctrl_lo,
   input wire logic       overtemp_limit,
   input wire logic       vconn_current_limit,
   // Outputs
   input wire logic       converter_en,
   input wire logic       load_switch_gate,
   input wire logic       vconn_cc1_en,
   input wire logic       vconn_cc2_en,
   input wire logic       adv_current_3a,
   input wire logic       client_mode,
   input wire logic       orientation_flag_n_o,
   input wire logic       orientation_flag_n_oe,
   input wire logic       load_detect_n_o,
   input wire logic       load_detect_n_oe,
   input wire logic       fault_n_o,
   input wire logic       fault_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Input ages
   // ------------------------------------------------------------
   // Ages saturate so that a long quiet stretch never wraps.
   int         cc_age_r;
   int         oc_age_r;
   logic [3:0] cc_last_r;
   logic       oc_last_r;

   always_ff @(posedge clk) begin
      cc_last_r <= {cc1_term, cc2_term};
      if ({cc1_term, cc2_term} != cc_last_r) cc_age_r <= 0;
      else if (cc_age_r < 1000) cc_age_r <= cc_age_r + 1;
   end

   always_ff @(posedge clk) begin
      oc_last_r <= vconn_current_limit;
      if (vconn_current_limit != oc_last_r) oc_age_r <= 0;
      else if (oc_age_r < 1000) oc_age_r <= oc_age_r + 1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   flags_low_a:
   assert property (!orientation_flag_n_o && !load_detect_n_o && !fault_n_o)
      else $error("open-drain flag driven high");
   gate_tracks_a:
   assert property (converter_en == load_switch_gate)
      else $error("gate and converter differ");
   conv_needs_sink_a:
   assert property (converter_en |-> load_detect_n_oe && !client_mode)
      else $error("converter on without sink");
   vconn_one_pin_a:
   assert property ((vconn_cc1_en || vconn_cc2_en) |-> load_detect_n_oe && !(vconn_cc1_en && vconn_cc2_en))
      else $error("vconn on wrongly");
   orient_idle_a:
   assert property (orientation_flag_n_oe |-> load_detect_n_oe)
      else $error("orientation asserted without sink");
   hot_off_a:
   assert property (overtemp_limit [*5] |-> !converter_en && !load_detect_n_oe
                    && !orientation_flag_n_oe && !vconn_cc1_en && !vconn_cc2_en)
      else $error("outputs on while hot");
   cdp_mode_a:
   assert property ((port_ctrl_hi && port_ctrl_lo) [*4] |-> adv_current_3a && !client_mode)
      else $error("code 11 not applied");
   client_mode_a:
   assert property (!port_ctrl_hi [*4] |-> client_mode && !adv_current_3a && !converter_en)
      else $error("client mode not applied");
   cc_debounce_a:
   assert property (($rose(converter_en) || $changed(load_detect_n_oe))
                    |-> cc_age_r >= CC_DEBOUNCE_CYC)
      else $error("output moved before debounce");
   fault_deglitch_a:
   assert property ($changed(fault_n_oe)
                    |-> oc_age_r >= VCONN_DEGLITCH_CYC && fault_n_oe == vconn_current_limit)
      else $error("fault flag not deglitched");
endmodule

bind typec_source_attach_logic typec_attach_chk #(
   .CC_DEBOUNCE_CYC(CC_DEBOUNCE_CYC),
   .VCONN_DEGLITCH_CYC(VCONN_DEGLITCH_CYC)
) chk_i (
   .clk(clk), .srst(srst), .cc1_term(cc1_term), .cc2_term(cc2_term),
   .port_ctrl_hi(port_ctrl_hi), .port_ctrl_lo(port_ctrl_lo), .overtemp_limit(overtemp_limit),
   .vconn_current_limit(vconn_current_limit), .converter_en(converter_en),
   .load_switch_gate(load_switch_gate), .vconn_cc1_en(vconn_cc1_en),
   .vconn_cc2_en(vconn_cc2_en), .adv_current_3a(adv_current_3a), .client_mode(client_mode),
   .orientation_flag_n_o(orientation_flag_n_o), .orientation_flag_n_oe(orientation_flag_n_oe),
   .load_detect_n_o(load_detect_n_o), .load_detect_n_oe(load_detect_n_oe),
   .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe)
);

// File: verification/typec_source_attach_logic_test.sv
// Self-checking bench for the Type-C source attach logic.
`include "typec_cfg.svh"

module typec_source_attach_logic_test import typec_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEB = 8;
   logic        clk = 1'h0;
   logic        srst = 1'h1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic        reg_wr = 1'h0, reg_rd = 1'h0;
   logic        hi = 1'h0, lo = 1'h0, hot = 1'h0, oc = 1'h0, flip = 1'h0;
   cc_term_t    near_t = 2'h0, far_t = 2'h0, cc1, cc2;
   logic        conv, gate, v1, v2, adv, ilim, cli, poe, loe, foe, irq;
   port_drive_t got;
   int          mismatches = 0, tests_run = 0, n;

   assign got = {conv, gate, v1, v2, poe, loe};
   always #2 clk = ~clk;

   typec_far_end far (.clk(clk), .near_term(near_t), .far_term(far_t), .flipped(flip),
                      .cc1_term(cc1), .cc2_term(cc2));
   typec_source_attach_logic #(.CC_DEBOUNCE_CYC(DEB), .VCONN_DEGLITCH_CYC(DEB)) uut (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cc1_term(cc1), .cc2_term(cc2),
      .port_ctrl_hi(hi), .port_ctrl_lo(lo), .overtemp_limit(hot), .vconn_current_limit(oc),
      .converter_en(conv), .load_switch_gate(gate), .vconn_cc1_en(v1), .vconn_cc2_en(v2),
      .adv_current_3a(adv), .ilimit_external(ilim), .client_mode(cli),
      .orientation_flag_n_o(), .orientation_flag_n_oe(poe), .load_detect_n_o(),
      .load_detect_n_oe(loe), .fault_n_o(), .fault_n_oe(foe), .irq(irq));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic close_out();
      $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // expected drive
   // Exactly one Rd means a sink; client mode keeps only the power path off.
   function automatic port_drive_t want(input cc_term_t a, b, input logic h);
      logic s;
      s = (a == 2'h1) ^ (b == 2'h1);
      return {s & h, s & h, s & (a == 2'h2), s & (b == 2'h2), s & (b == 2'h1), s};
   endfunction

   task automatic put(input cc_term_t a, b);
      logic f;
      f = 1'($urandom_range(1));
      @(posedge clk);
      flip <= f;
      near_t <= f ? b : a;
      far_t <= f ? a : b;
      repeat (20) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
   endtask

   task automatic await(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 60) begin
         @(posedge clk);
         #1 n++;
      end
      if (s !== v) begin
         chk(s, v);
         close_out();
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [1:0] a, b;
      void'($urandom(60));
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      #1 chk(got, 6'h00);
      chk({adv, ilim, cli}, 3'h1);
      rd(`REG_CTRL, 32'h1);
      rd(`REG_INT_MASK, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h0);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         hi <= m[1];
         lo <= m[0];
         repeat (8) @(posedge clk);
         #1 chk({adv, ilim, cli}, {m == 3, m[1], !m[1]});
         for (int k = 0; k < 16; k++) begin
            a = (m == 3) ? k[3:2] : 2'($urandom_range(3));
            b = (m == 3) ? k[1:0] : 2'($urandom_range(3));
            put(a, b);
            chk(got, want(a, b, m[1]));
         end
      end
      // A sink that leaves before the debounce ends must change nothing.
      @(posedge clk);
      near_t <= 2'h1;
      flip <= 1'h0;
      repeat (6) @(posedge clk);
      near_t <= 2'h0;
      n = 0;
      repeat (24) begin
         @(posedge clk);
         #1 n += (loe !== 1'h0);
      end
      chk(n, 0);
      put(2'h1, 2'h2);
      @(posedge clk);
      hot <= 1'h1;
      repeat (8) @(posedge clk);
      #1 chk(got, 6'h00);
      rd(`REG_STATUS, 32'h279);
      @(posedge clk);
      hot <= 1'h0;
      repeat (8) @(posedge clk);
      #1 chk(got, want(2'h1, 2'h2, 1'h1));
      // Parking the port through the control register drops every power path.
      wr(`REG_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      #1 chk(got, 6'h00);
      wr(`REG_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      #1 chk(got, want(2'h1, 2'h2, 1'h1));
      wr(`REG_INT_STAT, 32'h1F);
      rd(`REG_INT_STAT, 32'h0);
      @(posedge clk);
      oc <= 1'h1;
      await(foe, 1'h1);
      chk(n >= DEB, 1'h1);
      chk({v2, irq}, 2'h2);
      rd(`REG_INT_STAT, 32'h8);
      wr(`REG_INT_MASK, 32'h8);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'h1);
      wr(`REG_INT_STAT, 32'h8);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'h0);
      @(posedge clk);
      oc <= 1'h0;
      await(foe, 1'h0);
      chk(n >= DEB, 1'h1);
      close_out();
   end
endmodule
